// File: lbc_pkg.sv
// Shared constants for the backlight configuration register bank
package lbc_pkg;
    localparam int IDX_W = 6;
    localparam logic [5:0] IDX_BRIGHT = 6'h04;
    localparam logic [5:0] IDX_BOOST = 6'h05;
    localparam logic [5:0] IDX_CTRL = 6'h06;
    localparam logic [5:0] IDX_CONV_HI = 6'h08;
    localparam logic [5:0] IDX_CONV_LO = 6'h09;
    localparam logic [5:0] IDX_GAIN_RED = 6'h0a;
    localparam logic [5:0] IDX_GAIN_GREEN = 6'h0b;
    localparam logic [5:0] IDX_GAIN_BLUE = 6'h0c;
    localparam int ADDR_LSB = 2;
    localparam logic [7:0] RST_BRIGHT = 8'h00;
    localparam logic [7:0] RST_BOOST = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h04;
    localparam logic [7:0] RST_GAIN = 8'h80;
    localparam logic [7:0] MASK_BRIGHT = 8'h17;
    localparam logic [7:0] MASK_BOOST = 8'h1f;
    localparam logic [7:0] MASK_CTRL = 8'h3f;
    localparam int BRIGHT_SRC_BIT = 4;
    localparam int STEP_W = 3;
    localparam int CTRL_ACTIVE_BIT = 0;
    localparam int CTRL_BOOST_EN_BIT = 1;
    localparam int CTRL_ADAPT_BIT = 2;
    localparam int CTRL_LOADER_BIT = 3;
    localparam int CTRL_SENSOR_BIT = 4;
    localparam int CTRL_TEMP_BIT = 5;
    localparam int VCODE_W = 5;
    localparam logic [4:0] VCODE_MIN = 5'h05;
    localparam logic [4:0] VCODE_MAX = 5'h14;
    localparam int CONV_W = 12;
    localparam int GAIN_SHIFT = 7;
    localparam logic [7:0] LEVEL_ONE = 8'h01;
    localparam logic [7:0] LEVEL_MAX = 8'hff;
    localparam int NUM_COLOURS = 3;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_RDWAIT = 2'b10
    } lbc_bus_e;
endpackage

// File: lbc_colour_scale.sv
// Per-colour brightness times correction gain, saturated and registered
`timescale 1ns/1ns
module lbc_colour_scale
    import lbc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_level,
    input wire logic [7:0] i_gain,
    output logic [7:0] o_scaled
);
    logic [15:0] prod;
    logic [8:0] shifted;

    assign prod = {8'h00, i_level} * {8'h00, i_gain};
    assign shifted = prod[GAIN_SHIFT +: 9];

    // Gain of 128 is unity, 255 is near double
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_scaled <= 8'h00;
        end else if (shifted[8]) begin
            o_scaled <= LEVEL_MAX; // [R12]
        end else begin
            o_scaled <= shifted[7:0]; // [R12]
        end
    end

    gain_apply_a: assert property (@(posedge i_mclk) // [R12]
        disable iff (i_sys_rst)
        ##1 o_scaled == ((((16'($past(i_level)) * 16'($past(i_gain)))
            >> GAIN_SHIFT) > 16'h00ff) ? 8'hff
            : 8'((16'($past(i_level)) * 16'($past(i_gain)))
            >> GAIN_SHIFT)))
        else $error("colour scale does not match level times gain");
endmodule

// File: lbc_regs.sv
// AHB-Lite register bank for the RGB backlight driver configuration
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// R1 - With the source bit clear, brightness follows the external input.
// R2 - With the source bit set, brightness follows the three-bit step field.
// R3 - Step code n weighs two to the power n-7, code 0 is 1/128, 7 is full. The code gives level 1 << n, so code 7 gives 0x80, not 0xff.
// R4 - Boost code sets the target in 1 V steps, 00101 is 5 V, 10100 is 20 V.
// R5 - Temp source bit picks the external sensor if clear, red LED if set.
// R6 - Sensor input bit picks sensor input one if clear, input two if set.
// R7 - Adaptive bit resets to one and picks automatic voltage, else the code.
// R8 - Boost enable bit one turns the converter on when set, reset zero. The code also requires the active bit to be set.
// R9 - Active bit zero means standby when clear, active when set, reset 0.
// R10 - Boost loader enable bit sits at position three and resets to zero.
// R11 - Conversion result reads as high byte bits 11..8 and low byte 7..0.
// R12 - Each colour gain acts as code over 128, 1000 0000 unity and reset.
// R13 - Green and blue own gain registers with the red encoding and reset.
// R14 - Read-only and unused bits read their reset value and ignore writes.
module lbc_regs
    import lbc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [7:0] i_ext_brightness,
    input wire logic [11:0] i_conv_result,
    input wire logic i_conv_valid,
    input wire logic [4:0] i_adaptive_code,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_active,
    output logic o_boost_enable,
    output logic o_boost_adaptive,
    output logic [4:0] o_boost_code,
    output logic o_boost_loader_en,
    output logic o_comp_temp_select,
    output logic o_comp_sensor_select,
    output logic [7:0] o_brightness_level,
    output logic [7:0] o_red_level,
    output logic [7:0] o_green_level,
    output logic [7:0] o_blue_level
);
    lbc_bus_e bus_st_r;
    logic [IDX_W-1:0] addr_r;
    logic [7:0] bright_r;
    logic [7:0] boost_r;
    logic [7:0] ctrl_r;
    logic [7:0] gain_r [NUM_COLOURS];
    logic [7:0] colour_lvl [NUM_COLOURS];
    logic [CONV_W-1:0] conv_r;
    logic accept;
    logic wr_now;
    logic [7:0] wdata;

    function automatic logic [7:0] step_level(input logic [2:0] code);
        step_level = 8'(LEVEL_ONE << code);
    endfunction

    function automatic logic [4:0] clamp_vcode(input logic [4:0] code);
        if (code < VCODE_MIN) begin
            clamp_vcode = VCODE_MIN;
        end else if (code > VCODE_MAX) begin
            clamp_vcode = VCODE_MAX;
        end else begin
            clamp_vcode = code;
        end
    endfunction

    function automatic logic [7:0] rd_mux(input logic [IDX_W-1:0] idx,
        input logic [7:0] br, input logic [7:0] bo, input logic [7:0] ct,
        input logic [CONV_W-1:0] cv, input logic [7:0] gr,
        input logic [7:0] gg, input logic [7:0] gb);
        unique case (idx)
            IDX_BRIGHT: rd_mux = br;
            IDX_BOOST: rd_mux = bo;
            IDX_CTRL: rd_mux = ct;
            IDX_CONV_HI: rd_mux = {4'h0, cv[11:8]};
            IDX_CONV_LO: rd_mux = cv[7:0];
            IDX_GAIN_RED: rd_mux = gr;
            IDX_GAIN_GREEN: rd_mux = gg;
            IDX_GAIN_BLUE: rd_mux = gb;
            default: rd_mux = 8'h00;
        endcase
    endfunction

    assign accept = i_hsel & i_htrans[1] & i_hready;
    assign wr_now = (bus_st_r == BUS_WRITE);
    assign wdata = i_hwdata[7:0];

    // Bus phase tracking; reads take one wait state
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            bus_st_r <= BUS_IDLE;
            addr_r <= '0;
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h0000_0000;
            o_hresp <= 1'b0;
        end else begin
            o_hresp <= 1'b0;
            unique case (bus_st_r)
                BUS_IDLE, BUS_WRITE: begin
                    if (accept) begin
                        addr_r <= i_haddr[ADDR_LSB +: IDX_W];
                        bus_st_r <= i_hwrite ? BUS_WRITE : BUS_RDWAIT;
                        o_hreadyout <= i_hwrite;
                    end else begin
                        bus_st_r <= BUS_IDLE;
                        o_hreadyout <= 1'b1;
                    end
                end
                BUS_RDWAIT: begin
                    o_hrdata <= {24'h00_0000, rd_mux(addr_r, bright_r,
                        boost_r, ctrl_r, conv_r, gain_r[0], gain_r[1],
                        gain_r[2])}; // [R11] [R14]
                    o_hreadyout <= 1'b1;
                    bus_st_r <= BUS_IDLE;
                end
                default: begin
                    bus_st_r <= BUS_IDLE;
                    o_hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Control registers, writable bits only
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            bright_r <= RST_BRIGHT;
            boost_r <= RST_BOOST;
            ctrl_r <= RST_CTRL; // [R7] [R8] [R9] [R10]
        end else if (wr_now) begin
            if (addr_r == IDX_BRIGHT) begin
                bright_r <= wdata & MASK_BRIGHT; // [R14]
            end
            if (addr_r == IDX_BOOST) begin
                boost_r <= wdata & MASK_BOOST; // [R14]
            end
            if (addr_r == IDX_CTRL) begin
                ctrl_r <= wdata & MASK_CTRL; // [R14]
            end
        end
    end

    // Colour gains, all reset to unity
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            for (int c = 0; c < NUM_COLOURS; c++) begin
                gain_r[c] <= RST_GAIN; // [R12] [R13]
            end
        end else if (wr_now) begin
            for (int c = 0; c < NUM_COLOURS; c++) begin
                if (addr_r == IDX_GAIN_RED + 6'(c)) begin
                    gain_r[c] <= wdata; // [R13]
                end
            end
        end
    end

    // Conversion result capture
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            conv_r <= '0;
        end else if (i_conv_valid) begin
            conv_r <= i_conv_result; // [R11]
        end
    end

    // Mode and boost outputs
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_active <= 1'b0;
            o_boost_enable <= 1'b0;
            o_boost_adaptive <= 1'b1;
            o_boost_code <= VCODE_MIN;
            o_boost_loader_en <= 1'b0;
            o_comp_temp_select <= 1'b0;
            o_comp_sensor_select <= 1'b0;
        end else begin
            o_active <= ctrl_r[CTRL_ACTIVE_BIT]; // [R9]
            o_boost_enable <= ctrl_r[CTRL_BOOST_EN_BIT]
                & ctrl_r[CTRL_ACTIVE_BIT]; // [R8]
            o_boost_adaptive <= ctrl_r[CTRL_ADAPT_BIT]; // [R7]
            o_boost_code <= ctrl_r[CTRL_ADAPT_BIT]
                ? clamp_vcode(i_adaptive_code)
                : clamp_vcode(boost_r[VCODE_W-1:0]); // [R4] [R7]
            o_boost_loader_en <= ctrl_r[CTRL_LOADER_BIT]; // [R10]
            o_comp_temp_select <= ctrl_r[CTRL_TEMP_BIT]; // [R5]
            o_comp_sensor_select <= ctrl_r[CTRL_SENSOR_BIT]; // [R6]
        end
    end

    // Brightness source selection
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_brightness_level <= 8'h00;
        end else if (!ctrl_r[CTRL_ACTIVE_BIT]) begin
            o_brightness_level <= 8'h00; // [R9]
        end else if (bright_r[BRIGHT_SRC_BIT]) begin
            o_brightness_level <= // [R2] [R3]
                step_level(bright_r[STEP_W-1:0]);
        end else begin
            o_brightness_level <= i_ext_brightness; // [R1]
        end
    end

    for (genvar g = 0; g < NUM_COLOURS; g++) begin : g_colour
        lbc_colour_scale u_scale (
            .i_mclk(i_mclk),
            .i_sys_rst(i_sys_rst),
            .i_level(o_brightness_level),
            .i_gain(gain_r[g]),
            .o_scaled(colour_lvl[g])
        );
    end

    assign o_red_level = colour_lvl[0];
    assign o_green_level = colour_lvl[1];
    assign o_blue_level = colour_lvl[2];

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    // Bus handshake checks
    sequence rd_accept;
        accept && !i_hwrite;
    endsequence
    sequence rd_done;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    read_wait_a: assert property (rd_accept |=> rd_done) // [R14]
        else $error("read did not take exactly one wait state");
    write_fast_a: assert property (accept && i_hwrite // [R14]
        |=> o_hreadyout)
        else $error("write inserted a wait state");
    resp_okay_a: assert property (!o_hresp) // [R14]
        else $error("error response given");
    unmapped_zero_a: assert property (accept && !i_hwrite // [R14]
        && i_haddr[ADDR_LSB +: IDX_W] == 6'h07
        |=> ##1 o_hrdata == 32'h0000_0000)
        else $error("unmapped register did not read zero");
    conv_high_a: assert property (accept && !i_hwrite // [R11]
        && i_haddr[ADDR_LSB +: IDX_W] == IDX_CONV_HI
        |=> ##1 o_hrdata[31:4] == 28'h000_0000)
        else $error("high conversion byte has nonzero upper bits");
    conv_capture_a: assert property (i_conv_valid // [R11]
        |=> conv_r == $past(i_conv_result))
        else $error("conversion result not captured");

    // Register and output checks
    ctrl_ro_a: assert property (ctrl_r[7:6] == 2'b00 // [R14]
        && bright_r[7:5] == 3'b000 && bright_r[3] == 1'b0
        && boost_r[7:5] == 3'b000)
        else $error("read-only control bit changed");
    ctrl_write_a: assert property (wr_now && addr_r == IDX_CTRL // [R14]
        |=> ctrl_r == ($past(wdata) & MASK_CTRL))
        else $error("control write not applied to writable bits");
    gain_write_a: assert property (wr_now && addr_r == IDX_GAIN_GREEN // [R13]
        |=> gain_r[1] == $past(wdata))
        else $error("green gain write not applied");
    gain_blue_a: assert property (wr_now && addr_r == IDX_GAIN_BLUE // [R13]
        |=> gain_r[2] == $past(wdata))
        else $error("blue gain write not applied");
    step_level_a: assert property (ctrl_r[0] // [R2] [R3]
        && bright_r[BRIGHT_SRC_BIT]
        |=> o_brightness_level == 8'h01 << $past(bright_r[2:0]))
        else $error("step brightness weight wrong");
    ext_level_a: assert property (ctrl_r[0] // [R1]
        && !bright_r[BRIGHT_SRC_BIT]
        |=> o_brightness_level == $past(i_ext_brightness))
        else $error("external brightness not followed");
    standby_dark_a: assert property (!ctrl_r[0] // [R9]
        |=> o_brightness_level == 8'h00 && !o_active)
        else $error("brightness not zero in standby");
    boost_manual_a: assert property (!ctrl_r[CTRL_ADAPT_BIT] // [R4] [R7]
        && boost_r[4:0] >= 5'h05 && boost_r[4:0] <= 5'h14
        |=> o_boost_code == $past(boost_r[4:0]))
        else $error("manual boost code not applied");
    boost_adapt_a: assert property (ctrl_r[CTRL_ADAPT_BIT] // [R7]
        && i_adaptive_code >= 5'h05 && i_adaptive_code <= 5'h14
        |=> o_boost_code == $past(i_adaptive_code) && o_boost_adaptive)
        else $error("adaptive boost code not applied");
    boost_range_a: assert property (o_boost_code >= 5'h05 // [R4]
        && o_boost_code <= 5'h14)
        else $error("boost code outside five to twenty volts");
    boost_gate_a: assert property (!ctrl_r[1] || !ctrl_r[0] // [R8] [R9]
        |=> !o_boost_enable)
        else $error("boost enabled while off or in standby");
    sel_bits_a: assert property (##1 // [R5] [R6]
        o_comp_temp_select == $past(ctrl_r[5])
        && o_comp_sensor_select == $past(ctrl_r[4]))
        else $error("compensation select does not follow control");
    loader_bit_a: assert property (##1 // [R10]
        o_boost_loader_en == $past(ctrl_r[CTRL_LOADER_BIT]))
        else $error("loader enable does not follow control");
    reset_vals_a: assert property ($fell(i_sys_rst) // [R7] [R10] [R13]
        |-> ctrl_r == 8'h04 && gain_r[1] == 8'h80 && gain_r[2] == 8'h80)
        else $error("register reset values wrong");
endmodule

// File: lbc_regs_tb.sv
// Self-checking testbench for the backlight configuration register bank
`timescale 1ns/1ns
module testbench
    import lbc_pkg::*;
();
    logic i_mclk, i_sys_rst, i_hsel, i_hwrite, i_conv_valid;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd_v;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic [7:0] i_ext_brightness, c, b, e, gr, gg, gb, lvl;
    logic [11:0] i_conv_result, cv;
    logic [4:0] i_adaptive_code, a;
    logic o_hreadyout, o_hresp, o_active, o_boost_enable, o_boost_adaptive;
    logic o_boost_loader_en, o_comp_temp_select, o_comp_sensor_select;
    logic [4:0] o_boost_code;
    logic [7:0] o_brightness_level, o_red_level, o_green_level, o_blue_level;
    int fails, compares, cycles, i;
    integer seed;
    logic [5:0] idxs [8] = '{IDX_BRIGHT, IDX_BOOST, IDX_CTRL, IDX_CONV_HI,
        IDX_CONV_LO, IDX_GAIN_RED, IDX_GAIN_GREEN, IDX_GAIN_BLUE};
    logic [7:0] rsts [8] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h80,
        8'h80, 8'h80};
    logic [7:0] masks [8] = '{8'h17, 8'h1f, 8'h3f, 8'h00, 8'h00, 8'hff,
        8'hff, 8'hff};

    lbc_regs dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
        .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
        .i_ext_brightness(i_ext_brightness), .i_conv_result(i_conv_result),
        .i_conv_valid(i_conv_valid), .i_adaptive_code(i_adaptive_code),
        .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_active(o_active), .o_boost_enable(o_boost_enable),
        .o_boost_adaptive(o_boost_adaptive), .o_boost_code(o_boost_code),
        .o_boost_loader_en(o_boost_loader_en),
        .o_comp_temp_select(o_comp_temp_select),
        .o_comp_sensor_select(o_comp_sensor_select),
        .o_brightness_level(o_brightness_level), .o_red_level(o_red_level),
        .o_green_level(o_green_level), .o_blue_level(o_blue_level));

    always #25 i_mclk = ~i_mclk;

    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test;
        end
    end

    task check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic ahb(input logic w, input logic [5:0] idx,
            input logic [31:0] wd, output logic [31:0] rd);
        @(posedge i_mclk);
        i_htrans <= 2'b10;
        i_haddr <= {24'h00_0000, idx, 2'b00};
        i_hwrite <= w;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) @(posedge i_mclk);
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'b1) @(posedge i_mclk);
        rd = o_hrdata;
        check("hresp", o_hresp, 32'h0000_0000);
    endtask

    task wr(input logic [5:0] idx, input logic [31:0] d);
        ahb(1'b1, idx, d, rd_v);
    endtask

    task rdchk(input logic [5:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0000_0000, rd_v);
        check("read data", rd_v, exp);
    endtask

    task settle;
        repeat (4) @(posedge i_mclk);
        #1;
    endtask

    function automatic logic [4:0] clamp(input logic [4:0] v);
        return (v < 5'h05) ? 5'h05 : ((v > 5'h14) ? 5'h14 : v);
    endfunction

    function automatic logic [7:0] colour(input logic [7:0] l,
            input logic [7:0] g);
        logic [15:0] p;
        p = ({8'h00, l} * {8'h00, g}) >> 7;
        return (p > 16'h00ff) ? 8'hff : p[7:0];
    endfunction

    initial begin
        i_mclk = 1'b0;
        i_sys_rst = 1'b1;
        i_hsel = 1'b1;
        i_haddr = 32'h0000_0000;
        i_htrans = 2'b00;
        i_hwrite = 1'b0;
        i_hsize = 3'b010;
        i_hwdata = 32'h0000_0000;
        i_ext_brightness = 8'h00;
        i_conv_result = 12'h000;
        i_conv_valid = 1'b0;
        i_adaptive_code = 5'h00;
        seed = 32'h0000_4147;
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        #1;
        check("adaptive", o_boost_adaptive, 32'h0000_0001);
        check("boost code", o_boost_code, 32'h0000_0005);
        check("active", o_active, 32'h0000_0000);
        check("boost en", o_boost_enable, 32'h0000_0000);
        check("loader", o_boost_loader_en, 32'h0000_0000);
        for (i = 0; i < 8; i++)
            rdchk(idxs[i], 32'(rsts[i]));
        for (i = 0; i < 8; i++) begin
            wr(idxs[i], 32'hffff_ffff);
            rdchk(idxs[i], {24'h00_0000, masks[i]});
        end
        wr(6'h07, 32'hffff_ffff);
        rdchk(6'h07, 32'h0000_0000);
        rdchk(6'h3f, 32'h0000_0000);
        for (i = 0; i < 5; i++) begin
            cv = (i == 0) ? 12'hfff : 12'($random(seed));
            @(posedge i_mclk);
            i_conv_result <= cv;
            i_conv_valid <= 1'b1;
            @(posedge i_mclk);
            i_conv_valid <= 1'b0;
            i_conv_result <= ~cv;
            rdchk(IDX_CONV_HI, {28'h000_0000, cv[11:8]});
            rdchk(IDX_CONV_LO, {24'h00_0000, cv[7:0]});
        end
        for (i = 0; i < 10; i++) begin
            c = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'($random(seed)));
            wr(IDX_CTRL, {24'h00_0000, c});
            settle;
            check("active", o_active, c[0]);
            check("boost en", o_boost_enable, c[1] & c[0]);
            check("adaptive", o_boost_adaptive, c[2]);
            check("loader", o_boost_loader_en, c[3]);
            check("sensor sel", o_comp_sensor_select, c[4]);
            check("temp sel", o_comp_temp_select, c[5]);
            rdchk(IDX_CTRL, {24'h00_0000, c & 8'h3f});
        end
        wr(IDX_CTRL, 32'h0000_0001);
        for (i = 0; i < 32; i++) begin
            wr(IDX_BOOST, i);
            settle;
            check("boost code", o_boost_code, clamp(5'(i)));
            rdchk(IDX_BOOST, i);
        end
        wr(IDX_CTRL, 32'h0000_0005);
        for (i = 0; i < 8; i++) begin
            a = (i == 0) ? 5'h00 : ((i == 1) ? 5'h1f : 5'($random(seed)));
            @(posedge i_mclk);
            i_adaptive_code <= a;
            settle;
            check("adaptive code", o_boost_code, clamp(a));
        end
        wr(IDX_CTRL, 32'h0000_0001);
        for (i = 0; i < 24; i++) begin
            b = (i < 8) ? (8'h10 | 8'(i)) : 8'($random(seed));
            e = (i == 8) ? 8'hff : 8'($random(seed));
            gr = (i == 8) ? 8'hff : 8'($random(seed));
            gg = (i == 8) ? 8'h80 : 8'($random(seed));
            gb = 8'($random(seed));
            if (i == 8)
                b = 8'h00;
            wr(IDX_BRIGHT, {24'h00_0000, b});
            wr(IDX_GAIN_RED, {24'h00_0000, gr});
            wr(IDX_GAIN_GREEN, {24'h00_0000, gg});
            wr(IDX_GAIN_BLUE, {24'h00_0000, gb});
            @(posedge i_mclk);
            i_ext_brightness <= e;
            settle;
            lvl = b[4] ? (8'h01 << b[2:0]) : e;
            check("level", o_brightness_level, lvl);
            check("red", o_red_level, colour(lvl, gr));
            check("green", o_green_level, colour(lvl, gg));
            check("blue", o_blue_level, colour(lvl, gb));
        end
        wr(IDX_CTRL, 32'h0000_0000);
        settle;
        check("standby level", o_brightness_level, 32'h0000_0000);
        end_of_test;
    end
endmodule
